// >>> rivm_vector_map.sv
// reset and interrupt vector address generator
//
// Functional notes
// - every reset cause uses vector 1, at address 0x000 when fuse unprogrammed
// - external requests 0 and 1 at offsets 0x001 and 0x002
// - pin change groups 0..2 at offsets 0x003 to 0x005
// - watchdog at 0x006; timer 2 compare A, B, overflow at 0x007..0x009
// - timer 1 capture, compare A, B, overflow at 0x00A..0x00D
// - timer 0 compare A, B, overflow at 0x00E..0x010
// - SPI complete 0x011; USART receive, empty, transmit 0x012..0x014
// - ADC, EEPROM, comparator, two-wire, store ready at 0x015..0x019
// - programmed boot fuse moves reset address to boot loader address
// - vector select bit adds boot section start to every interrupt vector offset
// - reset address from fuse only; vector base from select bit only
// - one word per vector, consecutive numbers at consecutive words
`timescale 1ns/1ps

`include "rivm_regs.svh"

module rivm_vector_map
#(
   parameter int                          NUM_SRC   = `RIVM_NUM_SRC,
   parameter logic [`RIVM_ADDR_W-1:0]     BOOT_ADDR = `RIVM_BOOT_ADDR_DEF
)
(
   input  wire logic                      i_clk,
   input  wire logic                      i_sys_rst,
   input  wire logic                      i_boot_reset_fuse_n,
   input  wire logic                      i_vector_select_bit,
   input  wire logic                      i_global_enable,
   input  wire logic [NUM_SRC-1:0]        i_irq_pending,
   input  wire logic [NUM_SRC-1:0]        i_irq_enable,
   input  wire logic                      i_fetch_ready,
   output rivm_pkg::rivm_vec_type         o_vector,
   output logic [NUM_SRC-1:0]             o_irq_ack
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   rivm_pkg::rivm_state_type              state;
   rivm_pkg::rivm_state_type              next_state;
   logic                                  any_req;
   logic [`RIVM_SRC_IDX_W-1:0]            win_idx;
   logic [`RIVM_ADDR_W-1:0]               reset_addr;
   logic [`RIVM_ADDR_W-1:0]               vec_base;
   logic [`RIVM_ADDR_W-1:0]               vec_addr;
   logic [NUM_SRC-1:0]                    masked;

   // ----------------------------------------
   // address selection
   // ----------------------------------------
   // fuse low means programmed
   assign reset_addr = i_boot_reset_fuse_n ? `RIVM_APP_RESET_ADDR : BOOT_ADDR;
   // select bit alone chooses the table base
   assign vec_base = i_vector_select_bit ? BOOT_ADDR + `RIVM_VEC_BASE_OFS
                                         : `RIVM_VEC_BASE_OFS;
   // table index k sits one word past k-1; source order fixes every offset
   assign vec_addr = vec_base + `RIVM_ADDR_W'(win_idx);

   assign masked = i_global_enable ? (i_irq_pending & i_irq_enable) : '0;

   rivm_prio_enc
   #(
      .N (NUM_SRC),
      .W (`RIVM_SRC_IDX_W)
   )
   u_prio
   (
      .i_req (masked),
      .o_any (any_req),
      .o_idx (win_idx)
   );

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         // reset vector counts as a dispatch, so a gap cycle follows it
         rivm_pkg::RIVM_ST_RESET:
            if (i_fetch_ready)
               next_state = rivm_pkg::RIVM_ST_ACK;
         rivm_pkg::RIVM_ST_IDLE:
            if (any_req && i_fetch_ready)
               next_state = rivm_pkg::RIVM_ST_ACK;
         rivm_pkg::RIVM_ST_ACK:
            next_state = rivm_pkg::RIVM_ST_IDLE;
         default:
            next_state = rivm_pkg::RIVM_ST_RESET;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         state <= rivm_pkg::RIVM_ST_RESET;
      else
         state <= next_state;
   end

   // ----------------------------------------
   // vector output
   // ----------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_vector <= '0;
      else if (state == rivm_pkg::RIVM_ST_RESET && i_fetch_ready)
      begin
         o_vector.valid    <= 1'b1;
         o_vector.is_reset <= 1'b1;
         o_vector.addr     <= reset_addr;
         o_vector.src      <= '0;
      end
      else if (state == rivm_pkg::RIVM_ST_IDLE && any_req && i_fetch_ready)
      begin
         o_vector.valid    <= 1'b1;
         o_vector.is_reset <= 1'b0;
         o_vector.addr     <= vec_addr;
         o_vector.src      <= win_idx;
      end
      else
         o_vector <= '0;
   end

   // ----------------------------------------
   // acknowledge to the winning source
   // ----------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_irq_ack <= '0;
      else if (state == rivm_pkg::RIVM_ST_IDLE && any_req && i_fetch_ready)
         o_irq_ack <= NUM_SRC'(1) << win_idx;
      else
         o_irq_ack <= '0;
   end

endmodule : rivm_vector_map

// >>> rivm_regs.svh
// constants for the reset and interrupt vector map
`ifndef RIVM_REGS_SVH
`define RIVM_REGS_SVH

// ----------------------------------------
// address layout
// ----------------------------------------
`define RIVM_ADDR_W          12
`define RIVM_NUM_SRC         25
`define RIVM_APP_RESET_ADDR  12'h000
`define RIVM_VEC_BASE_OFS    12'h001
`define RIVM_BOOT_ADDR_DEF   12'hC00
`define RIVM_SRC_IDX_W       5

`endif

// >>> rivm_pkg.sv
// types for the reset and interrupt vector map
package rivm_pkg;

   // ----------------------------------------
   // sequencer state and vector answer
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      RIVM_ST_RESET = 2'b00,
      RIVM_ST_IDLE  = 2'b01,
      RIVM_ST_ACK   = 2'b10
   } rivm_state_type;

   typedef struct packed
   {
      logic        valid;
      logic        is_reset;
      logic [11:0] addr;
      logic [4:0]  src;
   } rivm_vec_type;

endpackage : rivm_pkg

// >>> rivm_prio_enc.sv
// lowest-index-first priority encoder
`timescale 1ns/1ps

module rivm_prio_enc
#(
   parameter int N = 25,
   parameter int W = 5
)
(
   input  wire logic [N-1:0] i_req,
   output logic              o_any,
   output logic [W-1:0]      o_idx
);

   // ----------------------------------------
   // scan from the top so the lowest wins
   // ----------------------------------------
   always_comb
   begin
      o_any = 1'b0;
      o_idx = '0;
      for (int k = N - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            o_any = 1'b1;
            o_idx = W'(k);
         end
      end
   end

endmodule : rivm_prio_enc

// >>> rivm_properties.sv
// checker for the vector map ports
`timescale 1ns/1ps

module rivm_chk
#(
   parameter int                NUM_SRC   = 25,
   parameter logic [11:0]       BOOT_ADDR = 12'hC00
)
(
   input wire logic                    i_clk,
   input wire logic                    i_sys_rst,
   input wire logic                    i_boot_reset_fuse_n,
   input wire logic                    i_vector_select_bit,
   input wire logic                    i_global_enable,
   input wire logic                    i_fetch_ready,
   input wire logic [NUM_SRC-1:0]      i_irq_pending,
   input wire logic [NUM_SRC-1:0]      i_irq_enable,
   input wire logic [NUM_SRC-1:0]      o_irq_ack,
   input wire rivm_pkg::rivm_vec_type  o_vector
);
   wire logic iv = o_vector.valid && !o_vector.is_reset;
   wire logic rv = o_vector.valid && o_vector.is_reset;
   logic [NUM_SRC-1:0] req_q;
   logic go_q;
   always_ff @(posedge i_clk) req_q <= i_irq_pending & i_irq_enable;
   always_ff @(posedge i_clk) go_q <= i_global_enable && i_fetch_ready;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   idle_zero_a: assert property (!o_vector.valid |-> o_vector == '0 && o_irq_ack == '0)
      else $error("outputs not zero while idle");
   int_addr_a: assert property (iv |-> o_vector.addr ==
      (($past(i_vector_select_bit) ? BOOT_ADDR : 12'h000) + 12'h001 + 12'(o_vector.src)))
      else $error("vector address wrong");
   rst_addr_a: assert property (rv |-> o_vector.src == '0 && o_irq_ack == '0 &&
      o_vector.addr == (i_boot_reset_fuse_n ? 12'h000 : BOOT_ADDR)) else $error("reset address wrong");
   ack_pair_a: assert property (iv |-> $onehot(o_irq_ack) && o_irq_ack[o_vector.src])
      else $error("ack does not match source");
   lowest_first_a: assert property (iv |-> (req_q & ((NUM_SRC'(1) << o_vector.src) - NUM_SRC'(1))) == '0)
      else $error("lower source skipped");
   taken_when_a: assert property (iv |-> go_q && req_q[o_vector.src])
      else $error("vector without request");
   rst_ready_a: assert property (rv |-> $past(i_fetch_ready))
      else $error("reset vector without ready");
   pulse_one_a: assert property (o_vector.valid |=> !o_vector.valid)
      else $error("vector held too long");
   cover property (rv && !i_boot_reset_fuse_n);
   cover property (iv && i_vector_select_bit);
   cover property (iv && $countones(req_q) > 1);
endmodule : rivm_chk

bind rivm_vector_map rivm_chk #(.NUM_SRC(NUM_SRC), .BOOT_ADDR(BOOT_ADDR)) chk (.i_clk, .i_sys_rst,
   .i_boot_reset_fuse_n, .i_vector_select_bit, .i_global_enable, .i_fetch_ready, .i_irq_pending,
   .i_irq_enable, .o_irq_ack, .o_vector);

// >>> rivm_core_model.sv
// core fetch side model, prompt or slow
`timescale 1ns/1ps

module rivm_core_model
(
   input  wire logic i_clk,
   input  wire logic i_slow,
   output logic      o_ready
);
   logic [1:0] cnt = 2'h0;
   always @(posedge i_clk) cnt <= cnt + 2'h1;
   assign o_ready = !i_slow || cnt == 2'h0;
endmodule : rivm_core_model

// >>> tb_top.sv
// self-checking bench for the vector map
`timescale 1ns/1ps

module tb_top;
   logic clk, rst, fuse_n, sel, gen, slow;
   logic [24:0] pend, ack, en;
   wire logic rdy;
   rivm_pkg::rivm_vec_type vec;
   int fail_count, cmp_count;
   rivm_vector_map dut (.i_clk(clk), .i_sys_rst(rst), .i_boot_reset_fuse_n(fuse_n), .i_vector_select_bit(sel),
      .i_global_enable(gen), .i_irq_pending(pend), .i_irq_enable(en), .i_fetch_ready(rdy),
      .o_vector(vec), .o_irq_ack(ack));
   rivm_core_model core (.i_clk(clk), .i_slow(slow), .o_ready(rdy));
   initial begin clk = 0; forever #12.5 clk = ~clk; end
   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      cmp_count++;
      if (got !== exp) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end
   endtask : chk
   task automatic wait_vec;
      repeat (20) begin @(posedge clk); #1; if (vec.valid === 1'b1) return; end
      chk(25'h0, 25'h1);
   endtask : wait_vec
   task automatic do_reset(input logic f);
      fuse_n = f; rst = 1; repeat (10) @(posedge clk); #1 rst = 0;
      wait_vec;
      chk(vec.is_reset, 25'h1);
      chk(vec.addr, f ? 25'h000 : 25'hC00);
   endtask : do_reset
   task automatic fire(input int k, input logic [11:0] base);
      @(posedge clk); #1 pend = 25'h1 << k; wait_vec; pend = 0;
      chk(vec.addr, 25'(base + 12'(k)));
      chk(ack, 25'h1 << k);
      chk(vec.src, 25'(k));
      chk(vec.is_reset, 25'h0);
   endtask : fire
   task automatic prio;
      @(posedge clk); #1 en = 25'h1FFFFF7; pend = 25'h8;
      repeat (4) begin @(posedge clk); #1 chk(vec.valid, 25'h0); end
      en = 25'h1FFFFFF; gen = 0; pend = 25'h100008;
      repeat (4) begin @(posedge clk); #1 chk(vec.valid, 25'h0); end
      gen = 1; wait_vec; chk(vec.src, 25'h3);
      pend = 25'h100000; wait_vec; pend = 0; chk(vec.src, 25'h14);
   endtask : prio
   task automatic tally_and_finish;
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      rst = 1; fuse_n = 1; sel = 0; gen = 1; slow = 0; pend = 0; fail_count = 0; cmp_count = 0;
      en = 25'h1FFFFFF;
      do_reset(1);
      for (int k = 0; k < 25; k++) fire(k, 12'h001);
      sel = 1; slow = 1;
      for (int k = 0; k < 25; k++) fire(k, 12'hC01);
      do_reset(0);
      sel = 0; fire(24, 12'h001);
      prio;
      tally_and_finish;
   end
   initial begin #50us; fail_count++; tally_and_finish; end
endmodule : tb_top
